// file: logic/ulp_if.sv
`timescale 1ns/1ns
interface ulp_if;
	import ulp_pkg::*;
	logic       ulpi_clk;
	logic       dir;
	logic       nxt;
	logic       stp;
	logic [7:0] phy_dout;
	logic       phy_oe;
	logic [7:0] link_dout;
	logic       link_oe;
	logic [7:0] data;

	// resolved bus level; an undriven bus reads as idle
	assign data = phy_oe ? phy_dout : (link_oe ? link_dout : BUS_IDLE);

	modport phy (
		output ulpi_clk, dir, nxt, phy_dout, phy_oe,
		input  stp, data
	);
	modport link (
		input  ulpi_clk, dir, nxt, data,
		output stp, link_dout, link_oe
	);
endinterface

// file: logic/ulp_link.sv
`timescale 1ns/1ns
module ulp_link
	import ulp_pkg::*;
#(
	parameter int STALE = STALE_CYC
) (
	input  wire logic       clk_sys,     // system clock
	input  wire logic       rst,         // sync reset
	ulp_if.link             bus,         // interface pins
	input  wire logic       cmd_valid,   // command request
	output logic            cmd_ready,   // command taken
	input  wire logic [1:0] cmd_op,      // write, read or transmit
	input  wire logic [7:0] cmd_addr,    // address or packet id
	input  wire logic [7:0] cmd_wdata,   // write value
	output logic [7:0]      rd_data,     // read value
	output logic            rd_valid,    // read value pulse
	input  wire logic [7:0] tx_data,     // packet byte
	input  wire logic       tx_last,     // last packet byte
	output logic            tx_ready,    // packet byte taken
	input  wire logic       wake,        // leave low power
	output logic            lp_mode,     // phy in low power
	output logic [1:0]      lp_line_state, // line state
	output logic            lp_irq       // phy interrupt
);
	typedef enum logic [6:0] {
		L_IDLE  = 7'h01, L_CMD   = 7'h02, L_XADDR = 7'h04,
		L_WDATA = 7'h08, L_STP   = 7'h10, L_RWAIT = 7'h20,
		L_TDATA = 7'h40
	} ulp_link_st_t;

	ulp_link_st_t state;
	logic         ck_s1;
	logic         ck_s2;
	logic         ck_s3;
	logic         dir_s1;
	logic         dir_s2;
	logic         nxt_s1;
	logic         nxt_s2;
	logic [7:0]   d_s1;
	logic [7:0]   d_s2;
	logic         rise;
	logic         dir_prev;
	logic         own;
	logic [1:0]   op;
	logic [7:0]   addr;
	logic [7:0]   wdata;
	logic         ext;
	logic         cur_last;
	logic [7:0]   dout;
	logic         oe;
	logic         stp_q;
	logic         wake_hold;
	logic [7:0]   stale;

	always_ff @(posedge clk_sys) begin
		ck_s1  <= bus.ulpi_clk;
		ck_s2  <= ck_s1;
		ck_s3  <= ck_s2;
		dir_s1 <= bus.dir;
		dir_s2 <= dir_s1;
		nxt_s1 <= bus.nxt;
		nxt_s2 <= nxt_s1;
		d_s1   <= bus.data;
		d_s2   <= d_s1;
	end
	// [RULE1] act on rising edge only
	assign rise = ck_s2 && !ck_s3;
	// [RULE4] own bus only after turnaround
	assign own  = !dir_s2 && !dir_prev;
	assign ext  = addr[7:6] != 2'h0 || ulp_ext(addr[5:0]);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dir_prev <= 1'b1;
		end else if (rise) begin
			dir_prev <= dir_s2;
		end
	end

	// [RULE11] command only while dir low
	assign cmd_ready = rise && own && state == L_IDLE && cmd_valid;
	assign tx_ready  = rise && nxt_s2 && ((state == L_CMD && op == CMD_TX)
		|| (state == L_TDATA && !cur_last));

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			op    <= CMD_WR;
			addr  <= 8'h00;
			wdata <= BUS_IDLE;
		end else if (cmd_ready) begin
			op    <= cmd_op;
			addr  <= cmd_addr;
			wdata <= cmd_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state    <= L_IDLE;
			dout     <= BUS_IDLE;
			oe       <= 1'b0;
			stp_q    <= 1'b0;
			cur_last <= 1'b0;
			rd_data  <= BUS_IDLE;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			if (rise) begin
				// [RULE2] drive only while dir low
				oe <= own;
				case (state)
				L_IDLE: begin
					// [RULE22] idle byte between commands
					dout <= BUS_IDLE;
					if (cmd_ready) begin
						state <= L_CMD;
						// [RULE7] command byte is non-zero
						if (cmd_op == CMD_TX) begin
							dout <= {CMD_TX, 2'h0, cmd_addr[3:0]};
						end else if (cmd_addr[7:6] != 2'h0 ||
							ulp_ext(cmd_addr[5:0])) begin
							dout <= {cmd_op, ADDR_EXT};
						end else begin
							dout <= {cmd_op, cmd_addr[5:0]};
						end
					end
				end
				L_CMD: begin
					// [RULE6] next byte after nxt
					if (nxt_s2) begin
						if (op == CMD_TX) begin
							dout     <= tx_data;
							cur_last <= tx_last;
							state    <= L_TDATA;
						end else if (ext) begin
							dout  <= addr;
							state <= L_XADDR;
						end else if (op == CMD_WR) begin
							dout  <= wdata;
							state <= L_WDATA;
						end else begin
							dout  <= BUS_IDLE;
							state <= L_RWAIT;
						end
					end
				end
				L_XADDR: begin
					if (nxt_s2) begin
						dout  <= (op == CMD_WR) ? wdata : BUS_IDLE;
						state <= (op == CMD_WR) ? L_WDATA : L_RWAIT;
					end
				end
				L_WDATA: begin
					// [RULE5] stop after last byte
					if (nxt_s2) begin
						dout  <= BUS_IDLE;
						stp_q <= 1'b1;
						state <= L_STP;
					end
				end
				L_STP: begin
					stp_q <= 1'b0;
					state <= L_IDLE;
				end
				L_RWAIT: begin
					if (dir_s2 && dir_prev) begin
						rd_data  <= d_s2;
						rd_valid <= 1'b1;
						state    <= L_IDLE;
					end
				end
				L_TDATA: begin
					if (nxt_s2) begin
						if (cur_last) begin
							dout  <= BUS_IDLE;
							stp_q <= 1'b1;
							state <= L_STP;
						end else begin
							dout     <= tx_data;
							cur_last <= tx_last;
						end
					end
				end
				default: state <= L_IDLE;
				endcase
			end
		end
	end

	// clock stopped while phy holds the bus means low power
	always_ff @(posedge clk_sys) begin
		if (rst || rise) begin
			stale <= 8'h00;
		end else if (stale != 8'(STALE)) begin
			stale <= stale + 8'h01;
		end
	end
	assign lp_mode = stale == 8'(STALE) && dir_s2;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lp_line_state <= 2'h0;
			lp_irq        <= 1'b0;
		end else if (lp_mode) begin
			lp_line_state <= d_s2[LS_LSB +: 2];
			lp_irq        <= d_s2[IRQ_BIT];
		end
	end

	// [RULE10] stop held until phy drops dir
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wake_hold <= 1'b0;
		end else if (wake && lp_mode) begin
			wake_hold <= 1'b1;
		end else if (!dir_s2) begin
			wake_hold <= 1'b0;
		end
	end

	assign bus.stp       = stp_q || wake_hold;
	assign bus.link_oe   = oe;
	assign bus.link_dout = dout;
endmodule

// file: logic/ulp_phy.sv
// What this block does
// [RULE1] PHY makes interface clock, rising edge only
// [RULE2] dir high takes bus, low listens
// [RULE3] dir held high until PLL ready
// [RULE4] one undriven turnaround cycle per dir change
// [RULE5] link stop ends stream, marks last
// [RULE6] nxt accepts byte, throttles transmit data
// [RULE7] transfers start with non-zero byte
// [RULE8] low power: clock stopped, line state shown
// [RULE9] low power interrupt on state changes
// [RULE10] stop wakes PHY into resume
// [RULE11] link waits dir low before command
// [RULE12] bits 7:6 type, all zero idle
// [RULE13] type 01 zero: transmit without PID
// [RULE14] type 01, bits 5:4 zero: PID
// [RULE15] type 10: immediate write, 6-bit address
// [RULE16] write address 2F: extended address follows
// [RULE17] type 11: immediate read, 6-bit address
// [RULE18] read address 2F: extended address follows
// [RULE19] register array kept in low power
// [RULE20] receive end delay within limit
// [RULE21] one decoder steers transmitter or registers
// [RULE22] link drives idle after write
// [RULE23] write latched on stop, nxt drops
`timescale 1ns/1ns
module ulp_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_sys,   // system clock
	input  wire logic         rst,       // sync reset
	input  wire logic         in_valid,  // write request
	output logic              in_ready,  // space free
	input  wire logic [W-1:0] in_data,   // write word
	output logic              out_valid, // word present
	input  wire logic         out_ready, // reader takes word
	output logic [W-1:0]      out_data   // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;

	assign in_ready  = cnt != (AW+1)'(DEPTH);
	assign out_valid = cnt != '0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rp];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else begin
			wp  <= wp + AW'(push);
			rp  <= rp + AW'(pop);
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module ulp_phy
	import ulp_pkg::*;
#(
	parameter int AW         = 8,
	parameter int FIFO_DEPTH = 16,
	parameter int HALF       = CLK_HALF
) (
	input  wire logic   clk_sys,      // system clock
	input  wire logic   rst,          // sync reset
	ulp_if.phy          bus,          // interface pins
	input  wire logic   pll_ready,    // transceiver ready
	input  wire logic   lpm_req,      // enter low power
	input  wire logic [1:0] line_state, // bus line state
	input  wire logic   vbus_state,   // vbus comparator
	input  wire logic   id_state,     // id pin level
	output logic        tx_start,     // packet begins
	output logic [3:0]  tx_pid,       // packet id
	output logic        tx_pid_valid, // packet id present
	output logic        tx_valid,     // packet byte valid
	output logic [7:0]  tx_data,      // packet byte
	output logic        tx_last,      // last packet byte
	input  wire logic   tx_ready,     // transmitter takes byte
	output logic        reg_wr,       // register written
	output logic [AW-1:0] reg_addr,   // written address
	output logic [7:0]  reg_wdata,    // written value
	output logic        in_lpm        // low power active
);
	typedef enum logic [11:0] {
		ST_START = 12'h001, ST_TURN  = 12'h002, ST_IDLE  = 12'h004,
		ST_ACC   = 12'h008, ST_XADDR = 12'h010, ST_WDATA = 12'h020,
		ST_WSTP  = 12'h040, ST_RTURN = 12'h080, ST_RDATA = 12'h100,
		ST_TDATA = 12'h200, ST_TLAST = 12'h400, ST_LPM   = 12'h800
	} ulp_phy_st_t;

	ulp_phy_st_t   state;
	ulp_phy_st_t   next_state;
	logic [7:0]    div_cnt;
	logic          clk_q;
	logic          rise;
	logic          fall;
	logic          lpm_quiet;
	logic [7:0]    d_s1;
	logic [7:0]    d_s2;
	logic          stp_s1;
	logic          stp_s2;
	logic [1:0]    op;
	logic [AW-1:0] addr;
	logic [7:0]    wdata;
	logic [7:0]    regs [2**AW];
	logic          dir_q;
	logic          nxt_q;
	logic          oe_q;
	logic [7:0]    dout_q;
	logic          lp_irq;
	logic [1:0]    ls_q;
	logic          vb_q;
	logic          id_q;
	logic          pend_v;
	logic [7:0]    pend_b;
	logic          accept;
	logic          f_valid;
	logic          f_ready;
	logic          cmd_ok;
	logic [5:0]    pin_s1;
	logic [5:0]    pin_s2;
	logic          pll_ok;
	logic          lpm_go;
	logic [1:0]    ls_now;
	logic          vb_now;
	logic          id_now;

	// pins from outside the clock domain
	always_ff @(posedge clk_sys) begin
		pin_s1 <= {pll_ready, lpm_req, line_state, vbus_state, id_state};
		pin_s2 <= pin_s1;
	end
	assign {pll_ok, lpm_go, ls_now, vb_now, id_now} = pin_s2;

	// [RULE1] clock from divider
	always_ff @(posedge clk_sys) begin
		if (rst || lpm_quiet) begin
			div_cnt <= '0;
			clk_q   <= 1'b0;
		end else if (div_cnt == 8'(HALF - 1)) begin
			div_cnt <= '0;
			clk_q   <= !clk_q;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end
	assign rise = !lpm_quiet && div_cnt == 8'(HALF - 1) && !clk_q;
	assign fall = !lpm_quiet && div_cnt == 8'(HALF - 1) && clk_q;
	assign bus.ulpi_clk = clk_q;

	always_ff @(posedge clk_sys) begin
		d_s1   <= bus.data;
		d_s2   <= d_s1;
		stp_s1 <= bus.stp;
		stp_s2 <= stp_s1;
	end

	// [RULE12] type and idle check
	assign cmd_ok = d_s2[7:6] != CMD_SPEC &&
		!(d_s2[7:6] == CMD_TX && d_s2[5:4] != 2'h0);
	assign accept = rise && state == ST_TDATA && nxt_q && !stp_s2;

	// [RULE21] single command decoder
	always_comb begin
		next_state = state;
		case (state)
		// [RULE3] hold bus until ready
		ST_START: if (pll_ok) next_state = ST_TURN;
		// [RULE4] bus not sampled here
		ST_TURN:  next_state = ST_IDLE;
		// [RULE7] non-zero starts transfer
		ST_IDLE: begin
			if (d_s2 != BUS_IDLE) begin
				if (cmd_ok) next_state = ST_ACC;
			end else if (lpm_go) begin
				next_state = ST_LPM;
			end
		end
		ST_ACC: begin
			case (op)
			// [RULE13] transmit begins
			CMD_TX:  next_state = ST_TDATA;
			// [RULE16] extended write address next
			CMD_WR:  next_state = ulp_ext(addr[5:0]) ? ST_XADDR : ST_WDATA;
			// [RULE18] extended read address next
			default: next_state = ulp_ext(addr[5:0]) ? ST_XADDR : ST_RTURN;
			endcase
		end
		ST_XADDR: next_state = (op == CMD_WR) ? ST_WDATA : ST_RTURN;
		ST_WDATA: next_state = ST_WSTP;
		// [RULE23] wait for stop
		ST_WSTP:  if (stp_s2) next_state = ST_IDLE;
		ST_RTURN: next_state = ST_RDATA;
		ST_RDATA: next_state = ST_TURN;
		// [RULE5] stop ends stream
		ST_TDATA: if (stp_s2) next_state = ST_TLAST;
		ST_TLAST: if (!pend_v) next_state = ST_IDLE;
		default:  next_state = state;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= ST_START;
		end else if (state == ST_LPM) begin
			// [RULE10] stop starts resume
			if (lpm_quiet && stp_s2) state <= ST_START;
		end else if (rise) begin
			state <= next_state;
		end
	end

	// [RULE8] clock runs one turnaround cycle, then stops
	always_ff @(posedge clk_sys) begin
		if (rst || state != ST_LPM) begin
			lpm_quiet <= 1'b0;
		end else if (fall && dir_q) begin
			// stop at a falling edge so no short high pulse escapes
			lpm_quiet <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			op   <= CMD_SPEC;
			addr <= '0;
		end else if (rise && state == ST_IDLE && cmd_ok) begin
			// [RULE15] 6-bit immediate address
			op   <= d_s2[7:6];
			addr <= AW'(d_s2[5:0]);
		end else if (rise && state == ST_XADDR) begin
			addr <= AW'(d_s2);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdata <= BUS_IDLE;
		end else if (rise && state == ST_WDATA) begin
			wdata <= d_s2;
		end
	end

	// [RULE19] only reset clears the array
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 2**AW; i++) begin
				regs[i] <= BUS_IDLE;
			end
		end else if (rise && state == ST_WSTP && stp_s2) begin
			// [RULE23] latch on stop
			regs[addr] <= wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_wr    <= 1'b0;
			reg_addr  <= '0;
			reg_wdata <= BUS_IDLE;
		end else begin
			reg_wr <= rise && state == ST_WSTP && stp_s2;
			if (rise && state == ST_WSTP && stp_s2) begin
				reg_addr  <= addr;
				reg_wdata <= wdata;
			end
		end
	end

	// [RULE9] sticky low power interrupt
	always_ff @(posedge clk_sys) begin
		ls_q <= ls_now;
		vb_q <= vb_now;
		id_q <= id_now;
		if (rst || state != ST_LPM) begin
			lp_irq <= 1'b0;
		end else if (ls_q != ls_now || vb_q != vb_now ||
			id_q != id_now) begin
			lp_irq <= 1'b1;
		end
	end

	// [RULE14] packet id from bits 3:0
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_start     <= 1'b0;
			tx_pid       <= 4'h0;
			tx_pid_valid <= 1'b0;
		end else begin
			tx_start <= rise && state == ST_ACC && op == CMD_TX;
			if (rise && state == ST_ACC && op == CMD_TX) begin
				tx_pid       <= addr[3:0];
				tx_pid_valid <= addr[3:0] != 4'h0;
			end
		end
	end

	// [RULE5] hold one byte until stop marks it last
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_v <= 1'b0;
			pend_b <= BUS_IDLE;
		end else if (accept) begin
			pend_v <= 1'b1;
			pend_b <= d_s2;
		end else if (state == ST_TLAST && f_ready) begin
			pend_v <= 1'b0;
		end
	end
	assign f_valid = pend_v && (accept || state == ST_TLAST);

	ulp_fifo #(
		.W     (9),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (f_valid),
		.in_ready  (f_ready),
		.in_data   ({state == ST_TLAST, pend_b}),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  ({tx_last, tx_data})
	);

	// [RULE2] pins change at falling edge, stable at rising
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dir_q  <= 1'b1;
			nxt_q  <= 1'b0;
			oe_q   <= 1'b0;
			dout_q <= BUS_IDLE;
		end else if (fall || lpm_quiet) begin
			dir_q  <= state inside {ST_START, ST_RTURN, ST_RDATA, ST_LPM};
			// [RULE6] throttle on buffer space
			nxt_q  <= state inside {ST_ACC, ST_XADDR, ST_WDATA, ST_WSTP} ||
				(state == ST_TDATA && f_ready);
			// [RULE4] no drive in turnaround cycles
			oe_q   <= state == ST_RDATA || lpm_quiet;
			if (lpm_quiet) begin
				// [RULE8] line state on low bits
				dout_q <= BUS_IDLE;
				dout_q[LS_LSB +: 2] <= ls_now;
				dout_q[IRQ_BIT]     <= lp_irq;
			end else begin
				// [RULE20] read answer one cycle after turnaround
				// [RULE17] register value returned
				dout_q <= regs[addr];
			end
		end
	end

	assign bus.dir      = dir_q;
	assign bus.nxt      = nxt_q;
	assign bus.phy_oe   = oe_q;
	assign bus.phy_dout = dout_q;
	assign in_lpm       = state == ST_LPM;
endmodule

// file: logic/ulp_pkg.sv
package ulp_pkg;
	// transmit command type field, bits 7:6
	localparam logic [1:0] CMD_SPEC    = 2'h0;
	localparam logic [1:0] CMD_TX      = 2'h1;
	localparam logic [1:0] CMD_WR      = 2'h2;
	localparam logic [1:0] CMD_RD      = 2'h3;
	localparam logic [5:0] ADDR_EXT    = 6'h2F;
	localparam logic [7:0] BUS_IDLE    = 8'h00;
	// low power bus layout
	localparam int         LS_LSB      = 0;
	localparam int         IRQ_BIT     = 3;
	// nominal rate of the real interface clock
	localparam int         NOM_CLK_MHZ = 60;
	localparam int         SYS_CLK_NS  = 100;
	localparam int         LINK_CLK_NS = 800;
	localparam int         CLK_HALF    = LINK_CLK_NS / (2 * SYS_CLK_NS);
	// link treats the clock as stopped after this many idle cycles
	localparam int         STALE_CYC   = 4 * CLK_HALF;
	// receive end delay, in high speed clocks
	localparam int         HS_END_MAX  = 63;
	localparam int         HS_END_DLY  = 43;

	function automatic logic ulp_ext(input logic [5:0] f);
		return f == ADDR_EXT;
	endfunction
endpackage

// file: test/ulp_properties.sv
`timescale 1ns/1ns
module ulp_properties
	import ulp_pkg::*;
(
	input wire logic       clk_sys,  // system clock
	input wire logic       rst,      // sync reset
	input wire logic       ulpi_clk, // interface clock
	input wire logic       dir,      // phy owns bus
	input wire logic       nxt,      // byte accepted
	input wire logic       stp,      // link stop
	input wire logic       phy_oe,   // phy drives bus
	input wire logic       link_oe,  // link drives bus
	input wire logic [7:0] data      // resolved bus
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// stop lasts about one interface period
	sequence stp_period;
		stp [*4] ##[1:8] !stp;
	endsequence
	// phy lets nxt go soon after the stop
	sequence nxt_release;
		##[1:16] !nxt;
	endsequence

	a_bus_no_clash: assert property (!(phy_oe && link_oe))
		else $error("both ends drive the bus");
	a_phy_owns_drive: assert property (phy_oe |-> dir)
		else $error("phy drives while dir low");
	a_nxt_link_owns: assert property (nxt |-> !dir)
		else $error("nxt high while phy owns bus");
	a_turn_phy_quiet: assert property ($rose(dir) |-> !phy_oe [*4])
		else $error("phy drives in turnaround");
	a_turn_link_quiet: assert property ($fell(dir) |-> !link_oe [*4])
		else $error("link drives in turnaround");
	a_dir_mid_cycle: assert property ($rose(ulpi_clk) |-> $stable(dir))
		else $error("dir changed on rising clock edge");
	a_clk_half_high: assert property ($rose(ulpi_clk) |-> ulpi_clk [*4])
		else $error("interface clock high phase too short");
	a_stp_one_period: assert property ($rose(stp) && !dir |-> stp_period)
		else $error("stop not one period long");
	a_nxt_after_stop: assert property ($rose(stp) && !dir |-> nxt_release)
		else $error("nxt not dropped after stop");
	a_start_nonzero: assert property ($rose(nxt) |-> data != BUS_IDLE)
		else $error("transfer accepted on idle byte");
endmodule

// file: test/ulp_tb.sv
`timescale 1ns/1ns
module ulp_tb;
	import ulp_pkg::*;
	logic       clk_sys = 1'b0, rst = 1'b1, pll_ready = 1'b0, lpm_req = 1'b0;
	logic       vbus_state = 1'b0, id_state = 1'b0, p_tx_ready = 1'b0;
	logic       cmd_valid = 1'b0, l_tx_last = 1'b0, wake = 1'b0;
	logic [1:0] line_state = 2'h0, cmd_op = 2'h0;
	logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00, l_tx_data = 8'h00;
	logic [7:0] rd_data, p_tx_data, reg_addr, reg_wdata;
	logic       cmd_ready, rd_valid, l_tx_ready, tx_start, tx_pid_valid;
	logic       p_tx_valid, p_tx_last, reg_wr, in_lpm, lp_mode, lp_irq;
	logic       reg_wr_b, clk_seen, wr_b_seen = 1'b0;
	logic [3:0] tx_pid;
	logic [1:0] lp_line_state;
	logic [8:0] got[$];
	logic [7:0] adr[5] = '{8'h05, 8'h2F, 8'h80, 8'h3E, 8'h11};
	logic [7:0] val[5] = '{8'hA5, 8'h5A, 8'hC3, 8'h01, 8'h00};
	int         n_mismatch = 0, comparisons = 0, cycles = 0;
	int         feed_idx = 0, n_pkt = 0, i;

	ulp_if ifa();
	ulp_if ifb();

	always #50 clk_sys = ~clk_sys;

	ulp_phy i_ulp_phy (.clk_sys, .rst, .bus(ifa), .pll_ready, .lpm_req,
		.line_state, .vbus_state, .id_state, .tx_start, .tx_pid, .tx_pid_valid,
		.tx_valid(p_tx_valid), .tx_data(p_tx_data), .tx_last(p_tx_last),
		.tx_ready(p_tx_ready), .reg_wr, .reg_addr, .reg_wdata, .in_lpm);
	// second phy faces a misbehaving link driven below
	ulp_phy i_ulp_phy_b (.clk_sys, .rst, .bus(ifb), .pll_ready, .lpm_req,
		.line_state, .vbus_state, .id_state, .tx_start(), .tx_pid(),
		.tx_pid_valid(), .tx_valid(), .tx_data(), .tx_last(),
		.tx_ready(p_tx_ready), .reg_wr(reg_wr_b), .reg_addr(), .reg_wdata(),
		.in_lpm());
	ulp_link i_ulp_link (.clk_sys, .rst, .bus(ifa), .cmd_valid, .cmd_ready,
		.cmd_op, .cmd_addr, .cmd_wdata, .rd_data, .rd_valid,
		.tx_data(l_tx_data), .tx_last(l_tx_last), .tx_ready(l_tx_ready), .wake,
		.lp_mode, .lp_line_state, .lp_irq);
	ulp_properties i_ulp_properties (.clk_sys, .rst, .ulpi_clk(ifa.ulpi_clk),
		.dir(ifa.dir), .nxt(ifa.nxt), .stp(ifa.stp), .phy_oe(ifa.phy_oe),
		.link_oe(ifa.link_oe), .data(ifa.data));

	function automatic logic [7:0] pat(input int k);
		return 8'h30 + k[7:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic do_cmd(input logic [1:0] op, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_valid <= 1'b1;
		for (k = 0; k < 400; k++) begin
			@(posedge clk_sys);
			if (cmd_ready === 1'b1) break;
		end
		cmd_valid <= 1'b0;
	endtask

	task automatic access(input logic [1:0] op, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		do_cmd(op, a, d);
		if (op == CMD_WR) begin
			for (k = 0; k < 400 && reg_wr !== 1'b1; k++) @(posedge clk_sys);
			check(reg_addr, a);
			check(reg_wdata, d);
			check(ifa.data, BUS_IDLE);
		end else begin
			for (k = 0; k < 400 && rd_valid !== 1'b1; k++) @(posedge clk_sys);
			check(rd_data, d);
		end
	endtask

	task automatic tx_packet(input logic [7:0] pid, input int n);
		int k;
		got.delete();
		n_pkt = n;
		feed_idx <= 0;
		l_tx_data <= pat(0);
		l_tx_last <= (n == 1);
		do_cmd(CMD_TX, pid, 8'h00);
		for (k = 0; k < 400 && tx_start !== 1'b1; k++) @(posedge clk_sys);
		check(tx_pid_valid, pid != 8'h00);
		if (pid != 8'h00) check(tx_pid, pid[3:0]);
		// transmitter stalls so the buffer fills
		tick(300);
		if (n > 17) check(feed_idx < n, 1'b1);
		p_tx_ready <= 1'b1;
		for (k = 0; k < 2000 && got.size() < n; k++) @(posedge clk_sys);
		p_tx_ready <= 1'b0;
		check(got.size(), n);
		for (k = 0; k < n; k++) check(got[k], {k == n - 1, pat(k)});
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (p_tx_valid === 1'b1 && p_tx_ready === 1'b1)
			got.push_back({p_tx_last, p_tx_data});
		if (l_tx_ready === 1'b1) begin
			feed_idx <= feed_idx + 1;
			l_tx_data <= pat(feed_idx + 1);
			l_tx_last <= (feed_idx + 2 == n_pkt);
		end
		if (reg_wr_b === 1'b1) wr_b_seen <= 1'b1;
		if (cycles == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		// command driven while the phy still owns the bus
		ifb.stp = 1'b0;
		ifb.link_oe = 1'b1;
		ifb.link_dout = {CMD_WR, 6'h05};
		tick(4);
		rst <= 1'b0;
		tick(40);
		check(ifa.dir, 1'b1);
		pll_ready <= 1'b1;
		ifb.link_dout <= BUS_IDLE;
		for (i = 0; i < 4; i++) access(CMD_WR, adr[i], val[i]);
		for (i = 0; i < 5; i++) access(CMD_RD, adr[i], val[i]);
		tx_packet(8'h0A, 20);
		tx_packet(8'h00, 3);
		line_state <= 2'h1;
		lpm_req <= 1'b1;
		for (i = 0; i < 400 && lp_mode !== 1'b1; i++) @(posedge clk_sys);
		lpm_req <= 1'b0;
		tick(8);
		check(in_lpm, 1'b1);
		check(lp_line_state, 2'h1);
		check(lp_irq, 1'b0);
		clk_seen = ifa.ulpi_clk;
		tick(20);
		check(ifa.ulpi_clk, clk_seen);
		line_state <= 2'h2;
		tick(10);
		check(lp_irq, 1'b1);
		check(lp_line_state, 2'h2);
		wake <= 1'b1;
		tick(1);
		wake <= 1'b0;
		for (i = 0; i < 400 && in_lpm !== 1'b0; i++) @(posedge clk_sys);
		check(in_lpm, 1'b0);
		access(CMD_RD, adr[2], val[2]);
		check(wr_b_seen, 1'b0);
		give_verdict();
	end
endmodule
